// ==== pvb_clamp_pulse.sv ====
// pvb_clamp_pulse: one delayed clamp pulse per trigger, timed in ns
// assumes delay and width stable while a pulse runs
`timescale 1ns/10ps
module pvb_clamp_pulse (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fire,
   input wire logic enable,
   input wire logic invert,
   input wire logic [10:0] delay_ns,
   input wire logic [10:0] width_ns,
   output logic pulse_q
);
   logic [11:0] t_q;
   logic run_q;
   logic [11:0] end_ns;
   logic active;

   assign end_ns = {1'b0, delay_ns} + {1'b0, width_ns};
   assign active = run_q && (t_q >= {1'b0, delay_ns}) && (t_q < end_ns);

   // ------------------------------------------------------------
   // elapsed time since trigger
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         t_q <= 12'h000;
         run_q <= 1'b0;
      end else if (fire) begin
         t_q <= 12'h000;
         run_q <= 1'b1;
      end else if (run_q) begin
         if (t_q >= end_ns) begin
            run_q <= 1'b0;
         end else begin
            t_q <= t_q + 12'(pvb_pkg::CLK_PERIOD_NS);
         end
      end
   end

   // ------------------------------------------------------------
   // output with polarity
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= enable & (active ^ invert);
      end
   end
endmodule // pvb_clamp_pulse

// ==== pvb_cmd_bank.sv ====
// pvb_cmd_bank: vendor command bank with limits, clamp timing, address offset,
// dynamic bus voltage, debug buffer, password security and protect mask
// assumes a transaction layer that strips address, byte count and PEC
// Overview of operation
// RL1: hold min on-time and min deadtime bytes
// RL2: clamp pulse delay in four-ns units
// RL3: clamp pulse width in four-ns units
// RL4: mode selects dual inverted or single doubled
// RL5: bus address is base plus offset while pin one syncs, else base alone
// RL6: mid/high level switch on current thresholds
// RL7: low/mid level switch on current thresholds
// RL8: hold mid and low voltage levels
// RL9: debug read returns buffer contents
// RL10: twelve-byte setup; valid new password secures
// RL11: password reads zero; default password zero
// RL12: correct password lifts protection until reset
// RL13: unlock command refused while security off
// RL14: read-only mask blocks secured commands
// RL15: turn counts read as two nibbles
// RL16: oscillator trim reads as a byte
// RL17: protected write refused, value kept
`timescale 1ns/10ps
module pvb_cmd_bank #(
   parameter logic [15:0] CLAMP_CFG = 16'h0000,
   parameter logic [255:0] PROTECT_MASK = 256'h0,
   parameter logic [7:0] TURNS = 8'h00,
   parameter logic [7:0] OSC_TRIM = 8'h00
) (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_CODE,
   input wire logic WR_VALID,
   input wire logic [7:0] WR_DATA,
   input wire logic WR_END,
   input wire logic RD_REQ,
   output logic [7:0] RD_DATA,
   output logic RD_VALID,
   output logic ACK,
   output logic NACK,
   output logic CMD_LOCKED,
   input wire logic [7:0] ADDR_PIN_ZERO_BASE,
   input wire logic ADDR_PIN_ONE_SYNC,
   output logic [7:0] BUS_ADDR,
   output logic [7:0] MIN_ON_NS,
   output logic [7:0] MIN_DEADTIME_NS,
   input wire logic PWM_PERIOD_START,
   input wire logic PWM_HALF_START,
   output logic CLAMP_A,
   output logic CLAMP_B,
   input wire logic signed [7:0] IOUT_CODE,
   output logic [2:0] DBV_LEVEL,
   output logic [7:0] VOUT_MID,
   output logic [7:0] VOUT_LOW,
   input wire logic DEBUG_LOAD,
   input wire logic [63:0] DEBUG_IN,
   output logic SECURITY_ON
);
   logic ovf_q, security_on_q, unlocked_q, rd_valid_q, ack_q, nack_q, locked_q, prot;
   logic pw_match, wr_ok, commit, writable, readable, clamp_mode;
   logic [7:0] cmd_q, addr_ofs_q, bus_addr_q, rd_data_q, clamp_wid;
   logic [3:0] wcnt_q;
   logic [95:0] wbuf_q;
   logic [4:0] rd_idx_q;
   logic [15:0] min_duty_q;
   logic [47:0] dbv_cfg_q, pw_q;
   logic [63:0] debug_q;
   pvb_pkg::pvb_dbv_state_t dbv_q;
   logic [5:0] len;
   logic [255:0] rd_word;
   logic [6:0] clamp_dly;

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   always_comb begin
      len = pvb_pkg::LEN_NONE;
      readable = 1'b1;
      case (cmd_q)
         pvb_pkg::CMD_MIN_DUTY: len = pvb_pkg::LEN_WORD;
         pvb_pkg::CMD_CLAMP: len = pvb_pkg::LEN_WORD;
         pvb_pkg::CMD_ADDR_OFS: len = pvb_pkg::LEN_BYTE;
         pvb_pkg::CMD_BUS_VOLTAGE_LEVELS: len = pvb_pkg::LEN_DBV;
         pvb_pkg::CMD_DEBUG_BUFFER: len = pvb_pkg::LEN_DEBUG;
         pvb_pkg::CMD_PW_SETUP: len = pvb_pkg::LEN_PW_SETUP;
         pvb_pkg::CMD_UNLOCK_ONCE: len = pvb_pkg::LEN_PW;
         pvb_pkg::CMD_PROTECT_MASK: len = pvb_pkg::LEN_MASK;
         pvb_pkg::CMD_TURNS: len = pvb_pkg::LEN_BYTE;
         pvb_pkg::CMD_OSC_TRIM: len = pvb_pkg::LEN_BYTE;
         default: readable = 1'b0;
      endcase
   end
   assign writable = cmd_q inside {pvb_pkg::CMD_MIN_DUTY, pvb_pkg::CMD_ADDR_OFS,
      pvb_pkg::CMD_BUS_VOLTAGE_LEVELS, pvb_pkg::CMD_DEBUG_BUFFER, pvb_pkg::CMD_PW_SETUP,
      pvb_pkg::CMD_UNLOCK_ONCE};

   // RL14: mask gates secured commands
   assign prot = security_on_q && !unlocked_q && PROTECT_MASK[cmd_q];
   assign pw_match = (wbuf_q[47:0] == pw_q);

   // RL17: protected or malformed writes refused
   always_comb begin
      wr_ok = writable && !prot && !ovf_q && ({2'b00, wcnt_q} == len);
      if (cmd_q == pvb_pkg::CMD_PW_SETUP) begin
         wr_ok = wr_ok && pw_match;
      end
      // RL13: unlock needs security on
      if (cmd_q == pvb_pkg::CMD_UNLOCK_ONCE) begin
         wr_ok = wr_ok && pw_match && security_on_q;
      end
   end
   assign commit = WR_END && wr_ok;

   // ------------------------------------------------------------
   // transfer tracking
   // ------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         cmd_q <= 8'h00;
         wcnt_q <= 4'h0;
         ovf_q <= 1'b0;
         wbuf_q <= 96'h0;
         rd_idx_q <= 5'h00;
      end else if (CMD_VALID) begin
         cmd_q <= CMD_CODE;
         wcnt_q <= 4'h0;
         ovf_q <= 1'b0;
         rd_idx_q <= 5'h00;
      end else begin
         if (WR_VALID) begin
            if (wcnt_q < pvb_pkg::WBUF_BYTES) begin
               wbuf_q[{wcnt_q, 3'b000} +: 8] <= WR_DATA;
               wcnt_q <= wcnt_q + 4'h1;
            end else begin
               ovf_q <= 1'b1;
            end
         end
         if (RD_REQ) begin
            rd_idx_q <= rd_idx_q + 5'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // writable settings
   // ------------------------------------------------------------
   // RL1: minimum duty and deadtime
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         min_duty_q <= pvb_pkg::MIN_DUTY_RST;
      end else if (commit && cmd_q == pvb_pkg::CMD_MIN_DUTY) begin
         min_duty_q <= wbuf_q[15:0];
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         addr_ofs_q <= pvb_pkg::ADDR_OFS_RST;
      end else if (commit && cmd_q == pvb_pkg::CMD_ADDR_OFS) begin
         addr_ofs_q <= wbuf_q[7:0];
      end
   end

   // RL8: voltage levels and thresholds
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         dbv_cfg_q <= pvb_pkg::DBV_RST;
      end else if (commit && cmd_q == pvb_pkg::CMD_BUS_VOLTAGE_LEVELS) begin
         dbv_cfg_q <= wbuf_q[47:0];
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         debug_q <= pvb_pkg::DEBUG_RST;
      end else if (commit && cmd_q == pvb_pkg::CMD_DEBUG_BUFFER) begin
         debug_q <= wbuf_q[63:0];
      end else if (DEBUG_LOAD) begin
         debug_q <= DEBUG_IN;
      end
   end

   // ------------------------------------------------------------
   // password security
   // ------------------------------------------------------------
   // RL10: new password turns security on
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         pw_q <= pvb_pkg::PW_RST;
         security_on_q <= 1'b0;
      end else if (commit && cmd_q == pvb_pkg::CMD_PW_SETUP) begin
         pw_q <= wbuf_q[pvb_pkg::PW_NEW_LSB +: 48];
         security_on_q <= 1'b1;
      end
   end

   // RL12: unlock holds until reset
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         unlocked_q <= 1'b0;
      end else if (commit && cmd_q == pvb_pkg::CMD_UNLOCK_ONCE) begin
         unlocked_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // answers
   // ------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         ack_q <= 1'b0;
         nack_q <= 1'b0;
      end else begin
         ack_q <= commit;
         // RL13: unlock refused while unsecured
         if (CMD_VALID) begin
            nack_q <= (CMD_CODE == pvb_pkg::CMD_UNLOCK_ONCE) && !security_on_q;
         end else if (RD_REQ) begin
            nack_q <= !readable ||
                      (cmd_q == pvb_pkg::CMD_UNLOCK_ONCE && !security_on_q);
         end else begin
            nack_q <= WR_END && !wr_ok;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         locked_q <= 1'b0;
      end else begin
         locked_q <= prot;
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_comb begin
      rd_word = 256'h0;
      case (cmd_q)
         pvb_pkg::CMD_MIN_DUTY: rd_word[15:0] = min_duty_q;
         pvb_pkg::CMD_CLAMP: rd_word[15:0] = CLAMP_CFG;
         pvb_pkg::CMD_ADDR_OFS: rd_word[7:0] = addr_ofs_q;
         pvb_pkg::CMD_BUS_VOLTAGE_LEVELS: rd_word[47:0] = dbv_cfg_q;
         // RL9: debug buffer contents
         pvb_pkg::CMD_DEBUG_BUFFER: rd_word[63:0] = debug_q;
         // RL11: password never readable
         pvb_pkg::CMD_PW_SETUP: rd_word = 256'h0;
         // RL14: mask is read-only
         pvb_pkg::CMD_PROTECT_MASK: rd_word = PROTECT_MASK;
         // RL15: primary and secondary turns
         pvb_pkg::CMD_TURNS: rd_word[7:0] = TURNS;
         // RL16: oscillator trim value
         pvb_pkg::CMD_OSC_TRIM: rd_word[7:0] = OSC_TRIM;
         default: rd_word = 256'h0;
      endcase
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         rd_data_q <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= RD_REQ;
         if (RD_REQ) begin
            rd_data_q <= rd_word[{rd_idx_q, 3'b000} +: 8];
         end
      end
   end

   // ------------------------------------------------------------
   // bus address
   // ------------------------------------------------------------
   // RL5: offset added when pin one syncs
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         bus_addr_q <= 8'h00;
      end else if (ADDR_PIN_ONE_SYNC) begin
         bus_addr_q <= 8'(ADDR_PIN_ZERO_BASE + addr_ofs_q);
      end else begin
         bus_addr_q <= ADDR_PIN_ZERO_BASE;
      end
   end

   // ------------------------------------------------------------
   // dynamic bus voltage level
   // ------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         dbv_q <= pvb_pkg::PVB_DBV_LOW;
      end else begin
         case (dbv_q)
            pvb_pkg::PVB_DBV_LOW: begin
               // RL7: low to mid
               if (IOUT_CODE > $signed(dbv_cfg_q[pvb_pkg::DBV_LOW_MID_LSB +: 8])) begin
                  dbv_q <= pvb_pkg::PVB_DBV_MID;
               end
            end
            pvb_pkg::PVB_DBV_MID: begin
               // RL6: mid to high
               if (IOUT_CODE > $signed(dbv_cfg_q[pvb_pkg::DBV_MID_HIGH_LSB +: 8])) begin
                  dbv_q <= pvb_pkg::PVB_DBV_HIGH;
               // RL7: mid to low
               end else if (IOUT_CODE < $signed(dbv_cfg_q[pvb_pkg::DBV_MID_LOW_LSB +: 8])) begin
                  dbv_q <= pvb_pkg::PVB_DBV_LOW;
               end
            end
            pvb_pkg::PVB_DBV_HIGH: begin
               // RL6: high back to mid
               if (IOUT_CODE < $signed(dbv_cfg_q[pvb_pkg::DBV_HIGH_MID_LSB +: 8])) begin
                  dbv_q <= pvb_pkg::PVB_DBV_MID;
               end
            end
            default: dbv_q <= pvb_pkg::PVB_DBV_LOW;
         endcase
      end
   end

   // ------------------------------------------------------------
   // active clamp drive
   // ------------------------------------------------------------
   assign clamp_mode = CLAMP_CFG[pvb_pkg::CLAMP_MODE_BIT];
   assign clamp_dly = CLAMP_CFG[pvb_pkg::CLAMP_DLY_LSB +: 7];
   assign clamp_wid = CLAMP_CFG[pvb_pkg::CLAMP_WID_LSB +: 8];

   // RL4: mode picks outputs and rate
   // RL2: delay scaled to ns
   // RL3: width scaled to ns
   pvb_clamp_pulse u_clamp_a (
      .clk(MCLK),
      .rst_n(RESETN),
      .fire(clamp_mode ? (PWM_PERIOD_START | PWM_HALF_START) : PWM_PERIOD_START),
      .enable(1'b1),
      .invert(!clamp_mode),
      .delay_ns({2'b00, clamp_dly, 2'b00}),
      .width_ns({1'b0, clamp_wid, 2'b00}),
      .pulse_q(CLAMP_A)
   );

   pvb_clamp_pulse u_clamp_b (
      .clk(MCLK),
      .rst_n(RESETN),
      .fire(PWM_HALF_START && !clamp_mode),
      .enable(!clamp_mode),
      .invert(1'b1),
      .delay_ns({2'b00, clamp_dly, 2'b00}),
      .width_ns({1'b0, clamp_wid, 2'b00}),
      .pulse_q(CLAMP_B)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign RD_DATA = rd_data_q;
   assign RD_VALID = rd_valid_q;
   assign ACK = ack_q;
   assign NACK = nack_q;
   assign CMD_LOCKED = locked_q;
   assign BUS_ADDR = bus_addr_q;
   assign MIN_ON_NS = min_duty_q[pvb_pkg::MIN_ON_LSB +: 8];
   assign MIN_DEADTIME_NS = min_duty_q[pvb_pkg::DEADTIME_LSB +: 8];
   assign DBV_LEVEL = dbv_q;
   assign VOUT_MID = dbv_cfg_q[pvb_pkg::DBV_VMID_LSB +: 8];
   assign VOUT_LOW = dbv_cfg_q[pvb_pkg::DBV_VLOW_LSB +: 8];
   assign SECURITY_ON = security_on_q;
endmodule // pvb_cmd_bank

// ==== pvb_cmd_bank_checker.sv ====
// pvb_cmd_bank_checker: port-level assertions for the command bank
// assumes binding to pvb_cmd_bank, one clock, async active-low reset
`timescale 1ns/10ps
module pvb_cmd_bank_checker (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_CODE,
   input wire logic WR_END,
   input wire logic RD_REQ,
   input wire logic RD_VALID,
   input wire logic ACK,
   input wire logic NACK,
   input wire logic [7:0] ADDR_PIN_ZERO_BASE,
   input wire logic ADDR_PIN_ONE_SYNC,
   input wire logic [7:0] BUS_ADDR,
   input wire logic [7:0] MIN_ON_NS,
   input wire logic [2:0] DBV_LEVEL,
   input wire logic SECURITY_ON
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   // ------------------------------------------------------------
   // answers and commits
   // ------------------------------------------------------------
   rd_answer_a: assert property (RD_REQ |=> RD_VALID)
      else $error("read request not answered");
   wr_answer_a: assert property (WR_END |=> (ACK ^ NACK))
      else $error("write end without single answer");
   ack_cause_a: assert property (ACK |-> $past(WR_END))
      else $error("ack without write end");
   duty_commit_a: assert property ($changed(MIN_ON_NS) |-> ACK)
      else $error("min on-time changed without commit");
   unlock_refuse_a: assert property ((CMD_VALID && CMD_CODE == pvb_pkg::CMD_UNLOCK_ONCE
      && !SECURITY_ON) |=> NACK)
      else $error("unlock not refused while unsecured");
   // ------------------------------------------------------------
   // address, levels, security
   // ------------------------------------------------------------
   addr_direct_a: assert property ($past(RESETN) && !$past(ADDR_PIN_ONE_SYNC)
      |-> BUS_ADDR == $past(ADDR_PIN_ZERO_BASE))
      else $error("bus address not base");
   dbv_onehot_a: assert property ($onehot(DBV_LEVEL))
      else $error("level not one-hot");
   dbv_step_a: assert property (DBV_LEVEL == pvb_pkg::PVB_DBV_LOW
      |=> DBV_LEVEL != pvb_pkg::PVB_DBV_HIGH)
      else $error("level skipped mid");
   sec_sticky_a: assert property (!$fell(SECURITY_ON))
      else $error("security dropped without reset");
   sec_rise_a: assert property ($rose(SECURITY_ON) |-> ACK)
      else $error("security on without commit");
endmodule // pvb_cmd_bank_checker

// ==== pvb_cmd_bank_tb.sv ====
// pvb_cmd_bank_tb: self-checking bench for the vendor command bank
// assumes pvb_pkg, pvb_host_model and the checker are compiled first
`timescale 1ns/10ps
module pvb_cmd_bank_tb;
   localparam logic [15:0] CLAMP = 16'h0D0D;
   localparam logic [255:0] MASK = 256'h1 << 8'hEB;
   localparam logic [7:0] TURNS_V = 8'h83;
   localparam logic [7:0] TRIM_V = 8'h5C;
   localparam logic [47:0] PW = 48'h6B73_6563_7572;
   logic mclk = 1'b0, resetn = 1'b0, cmd_valid, wr_valid, wr_end, rd_req, rd_valid;
   logic ack, nack, cmd_locked, addr_sync = 1'b0, pwm_period_start = 1'b0;
   logic pwm_half_start = 1'b0, clamp_a, clamp_b, debug_load = 1'b0, security_on;
   logic [7:0] cmd_code, wr_data, rd_data, addr_base = 8'h21, bus_addr, min_on_ns;
   logic [7:0] min_deadtime_ns, vout_mid, vout_low;
   logic signed [7:0] iout = 8'sh00;
   logic [2:0] dbv_level;
   logic [63:0] debug_in = 64'h0;
   logic [255:0] rdv;
   logic a, nk;
   int errors = 0, cmp_count = 0, cyc = 0;
   pvb_cmd_bank #(.CLAMP_CFG(CLAMP), .PROTECT_MASK(MASK), .TURNS(TURNS_V),
      .OSC_TRIM(TRIM_V)) i_pvb_cmd_bank (.MCLK(mclk), .RESETN(resetn),
      .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .WR_VALID(wr_valid), .WR_DATA(wr_data),
      .WR_END(wr_end), .RD_REQ(rd_req), .RD_DATA(rd_data), .RD_VALID(rd_valid),
      .ACK(ack), .NACK(nack), .CMD_LOCKED(cmd_locked), .ADDR_PIN_ZERO_BASE(addr_base),
      .ADDR_PIN_ONE_SYNC(addr_sync), .BUS_ADDR(bus_addr), .MIN_ON_NS(min_on_ns),
      .MIN_DEADTIME_NS(min_deadtime_ns), .PWM_PERIOD_START(pwm_period_start),
      .PWM_HALF_START(pwm_half_start), .CLAMP_A(clamp_a), .CLAMP_B(clamp_b),
      .IOUT_CODE(iout), .DBV_LEVEL(dbv_level), .VOUT_MID(vout_mid), .VOUT_LOW(vout_low),
      .DEBUG_LOAD(debug_load), .DEBUG_IN(debug_in), .SECURITY_ON(security_on));
   pvb_host_model i_host (.clk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .wr_valid(wr_valid), .wr_data(wr_data), .wr_end(wr_end), .rd_req(rd_req),
      .rd_data(rd_data), .rd_valid(rd_valid), .ack(ack), .nack(nack));
   // ------------------------------------------------------------
   // clock, timeout, compare, verdict
   // ------------------------------------------------------------
   always #25 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errors++;
         end_sim();
      end
   end
   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      if (errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk(security_on, 1'b0);
      chk({dbv_level, clamp_a, clamp_b}, 5'b001_11);
      i_host.rd(pvb_pkg::CMD_PW_SETUP, 12, rdv, nk);
      chk(rdv, '0);
   endtask
   task automatic t_duty();
      i_host.wr(pvb_pkg::CMD_MIN_DUTY, 2, 96'h1234, a, nk);
      chk({a, nk, min_on_ns, min_deadtime_ns}, 18'h2_1234);
      i_host.rd(pvb_pkg::CMD_MIN_DUTY, 2, rdv, nk);
      chk(rdv, 16'h1234);
   endtask
   task automatic t_clamp();
      int la;
      int lb;
      i_host.rd(pvb_pkg::CMD_CLAMP, 2, rdv, nk);
      chk(rdv, CLAMP);
      for (int k = 0; k < 2; k++) begin
         la = 0;
         lb = 0;
         pwm_period_start = (k == 0);
         pwm_half_start = (k == 1);
         @(negedge mclk);
         pwm_period_start = 1'b0;
         pwm_half_start = 1'b0;
         repeat (6) begin
            @(negedge mclk);
            la += !clamp_a;
            lb += !clamp_b;
         end
         chk(la, k == 0);
         chk(lb, k == 1);
      end
   endtask
   task automatic t_addr();
      addr_sync = 1'b1;
      i_host.wr(pvb_pkg::CMD_ADDR_OFS, 1, 96'hF0, a, nk);
      @(negedge mclk);
      chk(bus_addr, 8'h11);
      addr_sync = 1'b0;
      @(negedge mclk);
      chk(bus_addr, 8'h21);
   endtask
   task automatic dstep(input logic [7:0] v, input logic [2:0] e);
      iout = v;
      repeat (3) @(negedge mclk);
      chk(dbv_level, e);
   endtask
   task automatic t_dbv();
      i_host.wr(pvb_pkg::CMD_BUS_VOLTAGE_LEVELS, 6, 96'h4030_7A10_F033, a, nk);
      chk({vout_mid, vout_low}, 16'h7A33);
      dstep(8'h11, 3'b010);
      dstep(8'h41, 3'b100);
      dstep(8'h20, 3'b010);
      dstep(8'hEF, 3'b001);
   endtask
   task automatic t_ro();
      debug_in = 64'h0123_4567_89AB_CDEF;
      debug_load = 1'b1;
      @(negedge mclk);
      debug_load = 1'b0;
      i_host.rd(pvb_pkg::CMD_DEBUG_BUFFER, 8, rdv, nk);
      chk(rdv, debug_in);
      i_host.rd(pvb_pkg::CMD_TURNS, 1, rdv, nk);
      chk(rdv, TURNS_V);
      i_host.rd(pvb_pkg::CMD_OSC_TRIM, 1, rdv, nk);
      chk(rdv, TRIM_V);
      i_host.rd(pvb_pkg::CMD_PROTECT_MASK, 32, rdv, nk);
      chk(rdv, MASK);
      i_host.wr(pvb_pkg::CMD_TURNS, 1, 96'h55, a, nk);
      chk({a, nk}, 2'b01);
   endtask
   task automatic t_sec();
      i_host.wr(pvb_pkg::CMD_UNLOCK_ONCE, 6, 96'h0, a, nk);
      chk({a, nk}, 2'b01);
      i_host.wr(pvb_pkg::CMD_PW_SETUP, 12, {PW, 48'h1}, a, nk);
      chk({a, nk, security_on}, 3'b010);
      i_host.wr(pvb_pkg::CMD_PW_SETUP, 12, {PW, 48'h0}, a, nk);
      chk({a, nk, security_on}, 3'b101);
      i_host.wr(pvb_pkg::CMD_MIN_DUTY, 2, 96'h5678, a, nk);
      chk({a, nk, cmd_locked, min_on_ns}, 11'h312);
      i_host.wr(pvb_pkg::CMD_ADDR_OFS, 1, 96'h0, a, nk);
      chk({a, nk}, 2'b10);
      i_host.wr(pvb_pkg::CMD_UNLOCK_ONCE, 6, 96'h1, a, nk);
      chk({a, nk}, 2'b01);
      i_host.wr(pvb_pkg::CMD_UNLOCK_ONCE, 6, {48'h0, PW}, a, nk);
      chk({a, nk}, 2'b10);
      i_host.wr(pvb_pkg::CMD_MIN_DUTY, 2, 96'h5678, a, nk);
      chk({a, nk, cmd_locked, min_on_ns}, 11'h456);
      resetn = 1'b0;
      repeat (2) @(negedge mclk);
      resetn = 1'b1;
      @(negedge mclk);
      chk({min_on_ns, security_on}, 9'h000);
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      resetn = 1'b1;
      @(negedge mclk);
      t_reset();
      t_duty();
      t_clamp();
      t_addr();
      t_dbv();
      t_ro();
      t_sec();
      end_sim();
   end
endmodule // pvb_cmd_bank_tb
bind pvb_cmd_bank pvb_cmd_bank_checker i_pvb_cmd_bank_checker (.MCLK(MCLK),
   .RESETN(RESETN), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .WR_END(WR_END),
   .RD_REQ(RD_REQ), .RD_VALID(RD_VALID), .ACK(ACK), .NACK(NACK),
   .ADDR_PIN_ZERO_BASE(ADDR_PIN_ZERO_BASE), .ADDR_PIN_ONE_SYNC(ADDR_PIN_ONE_SYNC),
   .BUS_ADDR(BUS_ADDR), .MIN_ON_NS(MIN_ON_NS), .DBV_LEVEL(DBV_LEVEL),
   .SECURITY_ON(SECURITY_ON));

// ==== pvb_host_model.sv ====
// pvb_host_model: management host driving the bank's command port
// assumes pulses taken on rising clk; drives on falling edge
`timescale 1ns/10ps
module pvb_host_model (
   input wire logic clk,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic wr_valid,
   output logic [7:0] wr_data,
   output logic wr_end,
   output logic rd_req,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic ack,
   input wire logic nack
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      wr_valid = 1'b0;
      wr_data = 8'h00;
      wr_end = 1'b0;
      rd_req = 1'b0;
   end
   task automatic wr(input logic [7:0] code, input int n, input logic [95:0] d,
      output logic a, output logic nk);
      nk = 1'b0;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = code;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         nk |= nack;
         cmd_valid = 1'b0;
         wr_valid = 1'b1;
         wr_data = d[8*i +: 8];
      end
      @(negedge clk);
      nk |= nack;
      cmd_valid = 1'b0;
      wr_valid = 1'b0;
      wr_data = ~wr_data;
      wr_end = 1'b1;
      @(negedge clk);
      wr_end = 1'b0;
      a = ack;
      nk |= nack;
   endtask
   task automatic rd(input logic [7:0] code, input int n, output logic [255:0] d,
      output logic nk);
      d = '0;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = code;
      @(negedge clk);
      nk = nack;
      cmd_valid = 1'b0;
      rd_req = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         if (i == n - 1) rd_req = 1'b0;
         d[8*i +: 8] = rd_valid ? rd_data : 8'hxx;
      end
   endtask
endmodule // pvb_host_model

// ==== pvb_pkg.sv ====
// pvb_pkg: command codes, lengths, field positions, reset values and timing
// assumes one controller clock at the rate given below
package pvb_pkg;

   // ------------------------------------------------------------
   // command codes of the bank
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_MIN_DUTY = 8'hEB;
   localparam logic [7:0] CMD_CLAMP = 8'hEC;
   localparam logic [7:0] CMD_ADDR_OFS = 8'hEE;
   localparam logic [7:0] CMD_BUS_VOLTAGE_LEVELS = 8'hEF;
   localparam logic [7:0] CMD_DEBUG_BUFFER = 8'hF0;
   localparam logic [7:0] CMD_PW_SETUP = 8'hF1;
   localparam logic [7:0] CMD_UNLOCK_ONCE = 8'hF2;
   localparam logic [7:0] CMD_PROTECT_MASK = 8'hF4;
   localparam logic [7:0] CMD_TURNS = 8'hF5;
   localparam logic [7:0] CMD_OSC_TRIM = 8'hF6;

   // ------------------------------------------------------------
   // transfer lengths in data bytes
   // ------------------------------------------------------------
   localparam logic [5:0] LEN_NONE = 6'h00;
   localparam logic [5:0] LEN_BYTE = 6'h01;
   localparam logic [5:0] LEN_WORD = 6'h02;
   localparam logic [5:0] LEN_PW = 6'h06;
   localparam logic [5:0] LEN_DBV = 6'h06;
   localparam logic [5:0] LEN_DEBUG = 6'h08;
   localparam logic [5:0] LEN_PW_SETUP = 6'h0C;
   localparam logic [5:0] LEN_MASK = 6'h20;
   localparam logic [3:0] WBUF_BYTES = 4'hC;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int MIN_ON_LSB = 8;
   localparam int DEADTIME_LSB = 0;
   localparam int CLAMP_MODE_BIT = 15;
   localparam int CLAMP_DLY_LSB = 8;
   localparam int CLAMP_WID_LSB = 0;
   localparam int DBV_MID_HIGH_LSB = 40;
   localparam int DBV_HIGH_MID_LSB = 32;
   localparam int DBV_VMID_LSB = 24;
   localparam int DBV_LOW_MID_LSB = 16;
   localparam int DBV_MID_LOW_LSB = 8;
   localparam int DBV_VLOW_LSB = 0;
   localparam int PW_NEW_LSB = 48;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] MIN_DUTY_RST = 16'h0000;
   localparam logic [7:0] ADDR_OFS_RST = 8'h00;
   localparam logic [47:0] DBV_RST = 48'h0000_0000_0000;
   localparam logic [63:0] DEBUG_RST = 64'h0000_0000_0000_0000;
   localparam logic [47:0] PW_RST = 48'h0000_0000_0000;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_FREQ_MHZ = 20;
   localparam int CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
   localparam int CLAMP_UNIT_NS = 4;

   // ------------------------------------------------------------
   // dynamic bus voltage level states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PVB_DBV_LOW = 3'b001,
      PVB_DBV_MID = 3'b010,
      PVB_DBV_HIGH = 3'b100
   } pvb_dbv_state_t;

endpackage
